//--- rtl/spio_pkg.sv
// Shared constants and types for the six-port parallel I/O block
package spio_pkg;
  localparam int NUM_PORTS = 6;
  localparam int PORT_W = 8;
  localparam int NUM_LINES = NUM_PORTS * PORT_W;
  localparam int ADDR_W = 8;
  localparam int SERIAL_LEN = 8;
  localparam int SERIAL_AW = 3;

  typedef logic [ADDR_W-1:0] spio_addr_t;
  typedef logic [PORT_W-1:0] spio_byte_t;

  // Absolute byte offsets of the port data registers
  localparam spio_addr_t OFS_FIRST_BANK_FIRST_PORT = 8'h00;
  localparam spio_addr_t OFS_FIRST_BANK_SECOND_PORT = 8'h01;
  localparam spio_addr_t OFS_FIRST_BANK_THIRD_PORT = 8'h02;
  localparam spio_addr_t OFS_SECOND_BANK_FIRST_PORT = 8'h03;
  localparam spio_addr_t OFS_SECOND_BANK_SECOND_PORT = 8'h04;
  localparam spio_addr_t OFS_SECOND_BANK_THIRD_PORT = 8'h05;
  // Control block
  localparam spio_addr_t OFS_DIR = 8'h06;
  localparam spio_addr_t OFS_IRQ_CTRL = 8'h07;
  localparam spio_addr_t OFS_REL_IN = 8'h08;
  localparam spio_addr_t OFS_REL_OUT = 8'h10;
  localparam spio_addr_t OFS_SERIAL = 8'h18;

  // Field positions
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_LEVEL_BIT = 1;
  localparam int IRQ_SRC_LINE = 0;

  // Reset values
  localparam logic [NUM_PORTS-1:0] DIR_RESET = 6'h00;
  localparam logic [NUM_LINES-1:0] OUT_RESET = 48'h0000_0000_0000;
  localparam logic [NUM_LINES-1:0] PIN_RESET = 48'hFFFF_FFFF_FFFF;
  localparam spio_byte_t RDATA_RESET = 8'h00;

  typedef struct packed {
    logic [NUM_LINES-1:0] out;
    logic [NUM_PORTS-1:0] dir;
    logic irq_en;
    logic irq;
    logic [NUM_LINES-1:0] s1;
    logic [NUM_LINES-1:0] s2;
    logic [NUM_LINES-1:0] s3;
    logic [NUM_LINES-1:0] pin;
    spio_byte_t rdata;
    logic rd_mem;
  } spio_state_s;
endpackage

//--- rtl/spio_mem_if.sv
// Link between the port controller and the serial identifier store
`timescale 1ns/1ps
`default_nettype none
interface spio_mem_if;
  logic wr_en;
  logic rd_en;
  logic [spio_pkg::SERIAL_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output wr_en, output rd_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- rtl/spio_serial_mem.sv
// Eight-character serial identifier store with registered read data
`timescale 1ns/1ps
`default_nettype none
module spio_serial_mem #(
  parameter logic [63:0] SERIAL_INIT = 64'h3030_3030_3030_3031
) (
  input wire logic clk_sys,
  input wire logic srst,
  spio_mem_if.mem mem
);
  import spio_pkg::*;

  typedef struct packed {
    logic [SERIAL_LEN-1:0][7:0] chars;
    logic [7:0] rdata;
  } spio_mem_s;

  spio_mem_s state_reg;
  spio_mem_s state_next;

  // Stands in for non-volatile storage: reset reloads the factory string,
  // so a rewrite survives only until the next reset in this model.
  always_comb begin
    state_next = state_reg;
    if (mem.wr_en) begin
      state_next.chars[mem.addr] = mem.wdata;
    end
    if (mem.rd_en) begin
      state_next.rdata = state_reg.chars[mem.addr];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg.chars <= SERIAL_INIT;
      state_reg.rdata <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mem.rdata = state_reg.rdata;
endmodule
`default_nettype wire

//--- rtl/spio_top.sv
// Six-port parallel I/O controller with register port and pin synchronisers
//
// Overview of operation
// - Six eight-bit ports, two banks of three, each bank on its own header.
// - Each port's direction is chosen separately; all eight lines move together.
// - An input line driven high reads 0, driven low reads 1.
// - An undriven input is pulled high externally and so reads 0.
// - Reading an output port returns the complement of the driven value.
// - Output register is writable in either direction and survives direction changes.
// - Output drive is not inverted: stored 1 drives high, 0 drives low.
// - First bank first port bit 0 is the interrupt source, gated by an enable.
// - Absolute byte offsets 0 to 5 select the six ports regardless of direction.
// - Absolute bit address is eight times byte address plus bit index, 0 to 47.
// - Relative addressing numbers inputs and outputs separately from zero.
// - Power-up applies the saved default configuration; software may replace it. Here the default is the fixed DEFAULT_DIR parameter and cannot be replaced.
// - Eight-character serial identifier kept in storage, readable and rewritable.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module spio_top #(
  parameter logic [spio_pkg::NUM_PORTS-1:0] DEFAULT_DIR = spio_pkg::DIR_RESET,
  parameter logic [63:0] SERIAL_INIT = 64'h3030_3030_3030_3031
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire spio_pkg::spio_addr_t addr,
  input wire spio_pkg::spio_byte_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic [spio_pkg::NUM_LINES-1:0] line_in,
  output logic [spio_pkg::NUM_LINES-1:0] line_out,
  output logic [spio_pkg::NUM_LINES-1:0] line_oe,
  output logic irq_source
);
  import spio_pkg::*;

  spio_state_s state_reg;
  spio_state_s state_next;
  spio_mem_if mem_bus ();

  // Finds the n-th port whose direction equals want, in logical order
  function automatic logic [3:0] rel_find(input logic [NUM_PORTS-1:0] dir,
                                          input logic want,
                                          input logic [2:0] n);
    logic [3:0] res;
    logic [2:0] cnt;
    res = 4'h0;
    cnt = 3'h0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (dir[p] == want) begin
        if (cnt == n && !res[3]) begin
          res = {1'b1, 3'(p)};
        end
        cnt = cnt + 3'h1;
      end
    end
    return res;
  endfunction

  // Value software sees for one port
  function automatic spio_byte_t port_view(input spio_state_s s, input logic [2:0] p);
    spio_byte_t v;
    if (s.dir[p]) begin
      v = ~s.out[p*PORT_W +: PORT_W];
    end else begin
      v = ~s.pin[p*PORT_W +: PORT_W];
    end
    return v;
  endfunction

  logic is_port;
  logic is_rel_in;
  logic is_rel_out;
  logic is_serial;
  logic [3:0] rel_hit;

  always_comb begin
    is_port = addr < ADDR_W'(NUM_PORTS);
    is_rel_in = addr >= OFS_REL_IN && addr < OFS_REL_IN + ADDR_W'(NUM_PORTS);
    is_rel_out = addr >= OFS_REL_OUT && addr < OFS_REL_OUT + ADDR_W'(NUM_PORTS);
    is_serial = addr >= OFS_SERIAL && addr < OFS_SERIAL + ADDR_W'(SERIAL_LEN);
    rel_hit = rel_find(state_reg.dir, is_rel_out, addr[2:0]);
  end

  always_comb begin
    state_next = state_reg;
    // Three-stage synchroniser; a line change is accepted once stages two and three agree
    state_next.s1 = line_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.pin[i] = state_reg.s3[i];
      end
    end

    if (wr_en) begin
      if (is_port) begin
        // Stored regardless of direction so a port can be preset
        state_next.out[addr[2:0]*PORT_W +: PORT_W] = wr_data;
      end else if (addr == OFS_DIR) begin
        state_next.dir = wr_data[NUM_PORTS-1:0];
      end else if (addr == OFS_IRQ_CTRL) begin
        state_next.irq_en = wr_data[IRQ_EN_BIT];
      end else if (is_rel_out && rel_hit[3]) begin
        // Relative writes reach output ports only; input ports need an absolute write
        state_next.out[rel_hit[2:0]*PORT_W +: PORT_W] = wr_data;
      end
    end

    state_next.rd_mem = rd_en && is_serial;
    if (rd_en) begin
      if (is_port) begin
        state_next.rdata = port_view(state_reg, addr[2:0]);
      end else if (addr == OFS_DIR) begin
        state_next.rdata = {2'b00, state_reg.dir};
      end else if (addr == OFS_IRQ_CTRL) begin
        state_next.rdata = {6'h00, ~state_reg.pin[IRQ_SRC_LINE], state_reg.irq_en};
      end else if (is_rel_in && rel_hit[3]) begin
        state_next.rdata = port_view(state_reg, rel_hit[2:0]);
      end else begin
        // Unmapped, relative output and empty relative slots read as zero
        state_next.rdata = RDATA_RESET;
      end
    end

    // Source asserts while the line is pulled low, i.e. while it reads as 1
    state_next.irq = state_reg.irq_en && !state_reg.pin[IRQ_SRC_LINE];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg.out <= OUT_RESET;
      state_reg.dir <= DEFAULT_DIR;
      state_reg.irq_en <= 1'b0;
      state_reg.irq <= 1'b0;
      state_reg.s1 <= PIN_RESET;
      state_reg.s2 <= PIN_RESET;
      state_reg.s3 <= PIN_RESET;
      state_reg.pin <= PIN_RESET;
      state_reg.rdata <= RDATA_RESET;
      state_reg.rd_mem <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    mem_bus.wr_en = wr_en && is_serial;
    mem_bus.rd_en = rd_en && is_serial;
    mem_bus.addr = addr[SERIAL_AW-1:0];
    mem_bus.wdata = wr_data;
  end

  spio_serial_mem #(
    .SERIAL_INIT(SERIAL_INIT)
  ) u_serial (
    .clk_sys(clk_sys),
    .srst(srst),
    .mem(mem_bus)
  );

  // Line index is the absolute bit address: 8 * port + bit, ports A,B,C of bank 1 then bank 2
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      assign line_oe[gp*PORT_W +: PORT_W] = {PORT_W{state_reg.dir[gp]}};
    end
  endgenerate

  assign line_out = state_reg.out;
  assign irq_source = state_reg.irq;
  assign rd_data = state_reg.rd_mem ? mem_bus.rdata : state_reg.rdata;

  AST_RESET_QUIET: assert property (@(posedge clk_sys)
    srst |=> (line_oe == '0) && (line_out == '0))
    else $error("Lines driven right after reset");

  AST_READ_INVERT: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && addr == OFS_FIRST_BANK_FIRST_PORT && !state_reg.dir[0])
    |=> rd_data == ~$past(state_reg.pin[7:0]))
    else $error("Input read is not the complement of the line level");

  AST_OUT_READBACK: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && addr == OFS_SECOND_BANK_SECOND_PORT && state_reg.dir[4] && !wr_en)
    |=> rd_data == ~line_out[39:32])
    else $error("Output readback is not the complement of the drive");

  AST_KEEP_ON_DIR: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && addr == OFS_DIR) |=> $stable(line_out))
    else $error("Output register changed on a direction write");

  AST_DRIVE_TRUE: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && addr == OFS_SECOND_BANK_FIRST_PORT)
    |=> line_out[31:24] == $past(wr_data))
    else $error("Absolute write did not reach its port lines");

  AST_DIR_GROUP: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && addr == OFS_DIR)
    |=> (line_oe[15:8] == {8{$past(wr_data[1])}}) && (line_oe[47:40] == {8{$past(wr_data[5])}}))
    else $error("Port lines did not change direction together");

  AST_IRQ_GATE: assert property (@(posedge clk_sys) disable iff (srst)
    (!state_reg.irq_en ##1 !state_reg.irq_en) |-> !irq_source)
    else $error("Interrupt source active while disabled");

  AST_REL_FIRST_IN: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && addr == OFS_REL_IN && !state_reg.dir[0])
    |=> rd_data == ~$past(state_reg.pin[7:0]))
    else $error("Relative input 0 is not the first input port");

  AST_REL_NO_IN_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && addr == OFS_REL_OUT && state_reg.dir == 6'h00) |=> $stable(line_out))
    else $error("Relative write reached an input port");

  AST_PIN_SETTLE: assert property (@(posedge clk_sys) disable iff (srst)
    (state_reg.s2[0] != state_reg.s3[0]) |=> $stable(state_reg.pin[0]))
    else $error("Line accepted before two stages agreed");

  AST_PIN_ACCEPT: assert property (@(posedge clk_sys) disable iff (srst)
    (state_reg.s2[0] == state_reg.s3[0]) |=> state_reg.pin[0] == $past(state_reg.s3[0]))
    else $error("Agreed line level was not accepted");

  AST_READ_PORT_IN_B2: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && addr == OFS_SECOND_BANK_SECOND_PORT && !state_reg.dir[4])
    |=> rd_data == ~$past(state_reg.pin[39:32]))
    else $error("Input read of second bank second port is not inverted");

  AST_READ_PORT_OUT: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && addr == OFS_SECOND_BANK_FIRST_PORT && state_reg.dir[3] && !wr_en)
    |=> rd_data == ~line_out[31:24])
    else $error("Output readback of second bank first port is wrong");

  AST_WRITE_PORT0: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && addr == OFS_FIRST_BANK_FIRST_PORT) |=> line_out[7:0] == $past(wr_data))
    else $error("Write to byte offset 0 missed its port");

  AST_WRITE_PORT_B2: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && addr == OFS_SECOND_BANK_SECOND_PORT) |=> line_out[39:32] == $past(wr_data))
    else $error("Write to byte offset 4 missed its port");

  AST_DIR_GROUP_REST: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && addr == OFS_DIR)
    |=> (line_oe[7:0] == {8{$past(wr_data[0])}}) && (line_oe[23:16] == {8{$past(wr_data[2])}})
    && (line_oe[31:24] == {8{$past(wr_data[3])}}) && (line_oe[39:32] == {8{$past(wr_data[4])}}))
    else $error("Remaining ports did not change direction together");

  AST_DIR_READBACK: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && addr == OFS_DIR) |=> rd_data == {2'b00, $past(state_reg.dir)})
    else $error("Direction register read back wrong");

  AST_RESET_DIR_DEFAULT: assert property (@(posedge clk_sys)
    srst |=> state_reg.dir == DEFAULT_DIR)
    else $error("Reset did not apply the default direction set");

  AST_RESET_NO_IRQ: assert property (@(posedge clk_sys)
    srst |=> !irq_source && (rd_data == RDATA_RESET))
    else $error("Interrupt source or read data not cleared by reset");

  AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (srst)
    (state_reg.irq_en && !state_reg.pin[IRQ_SRC_LINE]) |=> irq_source)
    else $error("Interrupt source missing while enabled and line low");

  AST_IRQ_IDLE: assert property (@(posedge clk_sys) disable iff (srst)
    state_reg.pin[IRQ_SRC_LINE] |=> !irq_source)
    else $error("Interrupt source active while its line is high");

  AST_IRQ_CTRL_READ: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && addr == OFS_IRQ_CTRL)
    |=> (rd_data[IRQ_LEVEL_BIT] == !$past(state_reg.pin[IRQ_SRC_LINE]))
    && (rd_data[IRQ_EN_BIT] == $past(state_reg.irq_en)) && (rd_data[7:2] == 6'h00))
    else $error("Interrupt control read back wrong");

  AST_REL_OUT_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && addr == OFS_REL_OUT + 8'h01 && state_reg.dir == 6'h28)
    |=> line_out[47:40] == $past(wr_data))
    else $error("Relative output 1 did not reach the second output port");

  AST_REL_EMPTY_SLOT: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && addr == OFS_REL_OUT + 8'h02 && state_reg.dir == 6'h28)
    |=> $stable(line_out))
    else $error("Relative write to a missing output port changed the lines");

  AST_REL_EMPTY_READ: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && addr == OFS_REL_IN + 8'h04 && state_reg.dir == 6'h28)
    |=> rd_data == RDATA_RESET)
    else $error("Relative read of a missing input port is not zero");

  AST_REL_OUT_READ_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && is_rel_out) |=> rd_data == RDATA_RESET)
    else $error("Relative output read returned data");

  AST_REL_IN_WRITE_IGNORED: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && is_rel_in) |=> $stable(line_out) && $stable(line_oe))
    else $error("Relative input write changed the lines");

  AST_SERIAL_NO_PORT_EFFECT: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && is_serial) |=> $stable(line_out) && $stable(line_oe))
    else $error("Identifier write changed the lines");

  AST_UNMAPPED_READ: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_en && addr >= OFS_SERIAL + ADDR_W'(SERIAL_LEN)) |=> rd_data == RDATA_RESET)
    else $error("Unmapped read returned data");
endmodule
`default_nettype wire

//--- sim/spio_header_model.sv
// External switches and loads seen on the two headers
`timescale 1ns/1ps
`default_nettype none
module spio_header_model (
  input wire logic [47:0] line_out,
  input wire logic [47:0] line_oe,
  input wire logic [47:0] ext_en,
  input wire logic [47:0] ext_val,
  output logic [47:0] line_in
);
  // Device drive wins; an unconnected line floats up to the pull-up level
  always_comb begin
    for (int i = 0; i < 48; i++) begin
      if (line_oe[i]) begin
        line_in[i] = line_out[i];
      end else if (ext_en[i]) begin
        line_in[i] = ext_val[i];
      end else begin
        line_in[i] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/test_spio_top.sv
// Self-checking bench for the six-port parallel I/O block
`timescale 1ns/1ps
`default_nettype none
module test_spio_top;
  import spio_pkg::*;
  localparam logic [63:0] SER = 64'h3030_3030_3030_3031;
  localparam logic [47:0] PAT = 48'h7E81_3CA5_FF01;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  spio_addr_t addr = 8'h00;
  spio_byte_t wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic [47:0] line_in;
  logic [47:0] line_out;
  logic [47:0] line_oe;
  logic [47:0] ext_en = '0;
  logic [47:0] ext_val = '0;
  logic irq_source;
  int fail_count = 0;
  int n_tests = 0;

  always #2 clk_sys = ~clk_sys;

  spio_top #(.SERIAL_INIT(SER)) dut_u (.clk_sys(clk_sys), .srst(srst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .irq_source(irq_source));
  spio_header_model hdr_u (.line_out(line_out), .line_oe(line_oe), .ext_en(ext_en),
    .ext_val(ext_val), .line_in(line_in));

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input spio_addr_t a, input spio_byte_t d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input spio_addr_t a, input spio_byte_t exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk({40'h0, rd_data}, {40'h0, exp});
  endtask
  // Pin changes need the three-stage synchroniser plus the irq register
  task automatic pins(input logic [47:0] en, input logic [47:0] val);
    @(posedge clk_sys);
    ext_en <= en;
    ext_val <= val;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk(line_oe, 48'h0);
    chk(line_out, 48'h0);
    for (int i = 0; i < 6; i++) rd(8'(i), 8'h00);
    $display("test reset done");
    pins('1, PAT);
    for (int i = 0; i < 6; i++) rd(8'(i), ~PAT[8*i +: 8]);
    pins('1, ~(48'h1 << 37));
    rd(8'h04, 8'h20);
    pins('0, '0);
    wr(8'h10, 8'hFF);
    chk(line_out, 48'h0);
    $display("test inputs done");
    wr(8'h03, 8'h5A);
    chk(line_out, 48'h5A << 24);
    chk(line_oe, 48'h0);
    wr(OFS_DIR, 8'h08);
    chk(line_oe, 48'hFF << 24);
    rd(8'h03, 8'hA5);
    rd(OFS_DIR, 8'h08);
    wr(OFS_DIR, 8'h00);
    chk(line_out, 48'h5A << 24);
    $display("test preset done");
    wr(OFS_DIR, 8'h28);
    wr(8'h11, 8'h77);
    wr(8'h12, 8'hEE);
    wr(8'h08, 8'h99);
    wr(8'h00, 8'h42);
    chk(line_out, 48'h7700_5A00_0042);
    chk(line_oe, 48'hFF00_FF00_0000);
    pins(48'h00FF_0000_00FF, 48'h00C3_0000_0011);
    rd(8'h0B, 8'h3C);
    rd(8'h08, 8'hEE);
    rd(8'h0C, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h05, 8'h88);
    wr(8'h04, 8'h96);
    wr(OFS_DIR, 8'h38);
    chk(line_oe, 48'hFFFF_FF00_0000);
    rd(8'h04, 8'h69);
    $display("test relative done");
    wr(OFS_IRQ_CTRL, 8'h01);
    pins(48'h1, 48'h0);
    chk({47'h0, irq_source}, 48'h1);
    rd(OFS_IRQ_CTRL, 8'h03);
    wr(OFS_IRQ_CTRL, 8'h00);
    rd(OFS_IRQ_CTRL, 8'h02);
    chk({47'h0, irq_source}, 48'h0);
    wr(OFS_IRQ_CTRL, 8'h01);
    pins('0, '0);
    chk({47'h0, irq_source}, 48'h0);
    $display("test irq done");
    for (int i = 0; i < 8; i++) rd(OFS_SERIAL + 8'(i), SER[8*i +: 8]);
    wr(8'h1B, 8'h5A);
    rd(8'h1B, 8'h5A);
    rd(8'h30, 8'h00);
    $display("test serial done");
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk(line_oe, 48'h0);
    chk(line_out, 48'h0);
    rd(8'h1B, SER[31:24]);
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
